// [ioca_decoder.sv]
`timescale 1ns/1ns
`include "ioca_defines.svh"
module ioca_decoder
#(
	parameter int N_INT_DEV = `IOCA_DEV_LAST_INT + 1,
	parameter int N_INT_FUN = `IOCA_FUN_LAST_INT + 1
)
(
	input  wire logic                     clk_sys,
	input  wire logic                     rst_b,
	input  wire ioca_pkg::ioca_io_req_type io_req,
	input  wire logic [7:0]               port_secondary_bus,
	input  wire logic [7:0]               port_subordinate_bus,
	output logic                          io_rd_valid,
	output logic [31:0]                   io_rdata,
	output logic                          cfg_en,
	output ioca_pkg::ioca_target_type     cfg_target,
	output ioca_pkg::ioca_cfg_req_type    cfg_req,
	output logic [31:0]                   hub_cfg_addr,
	output logic [31:0]                   pcie_hdr_dw2,
	output ioca_pkg::ioca_io_fwd_type     io_fwd
);
	import ioca_pkg::*;

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// The host bridge and port bridge are always internal, and the
	// device and function fields are five and three bits wide.
	generate
		if (N_INT_DEV < 2 || N_INT_DEV > 32)
		begin : g_bad_dev_count
			$error("N_INT_DEV must lie in 2..32");
		end
		if (N_INT_FUN < 1 || N_INT_FUN > 8)
		begin : g_bad_fun_count
			$error("N_INT_FUN must lie in 1..8");
		end
		if (`IOCA_DEV_HOST >= N_INT_DEV || `IOCA_DEV_PORT >= N_INT_DEV)
		begin : g_bad_bridge_dev
			$error("Bridge devices must be internal");
		end
		if (`IOCA_BUS_HI - `IOCA_BUS_LO != 7)
		begin : g_bad_bus_field
			$error("Bus field must be 8 bits");
		end
		if (`IOCA_DEV_HI - `IOCA_DEV_LO != 4)
		begin : g_bad_dev_field
			$error("Device field must be 5 bits");
		end
		if (`IOCA_FUN_HI - `IOCA_FUN_LO != 2)
		begin : g_bad_fun_field
			$error("Function field must be 3 bits");
		end
		if (`IOCA_REG_HI - `IOCA_REG_LO != 5)
		begin : g_bad_reg_field
			$error("Register field must be 6 bits");
		end
		if (`IOCA_REG_LO != 2)
		begin : g_bad_reg_align
			$error("Register field must start at bit 2");
		end
		if (`IOCA_BUS_LO != `IOCA_DEV_HI + 1 || `IOCA_DEV_LO != `IOCA_FUN_HI + 1
			|| `IOCA_FUN_LO != `IOCA_REG_HI + 1)
		begin : g_bad_field_gap
			$error("Index fields must be contiguous");
		end
		if (`IOCA_EN_BIT <= `IOCA_BUS_HI || `IOCA_EN_BIT > 31)
		begin : g_bad_enable_bit
			$error("Enable bit must sit above the bus field");
		end
		if (((`IOCA_INDEX_MASK >> `IOCA_EN_BIT) & 32'h1) == 32'h0)
		begin : g_bad_mask
			$error("Enable bit must be writable");
		end
		if ((`IOCA_INDEX_RESET & ~`IOCA_INDEX_MASK) != 32'h0)
		begin : g_bad_reset
			$error("Reset value must not set reserved bits");
		end
		if (`IOCA_BE_DWORD != 4'hF)
		begin : g_bad_dword_be
			$error("Doubleword byte enables must be all ones");
		end
		if (`IOCA_INDEX_ADDR == `IOCA_DATA_ADDR)
		begin : g_bad_addr
			$error("Index and data addresses must differ");
		end
		if ((`IOCA_INDEX_ADDR & 16'h0003) != 16'h0000)
		begin : g_bad_addr_align
			$error("Index address must be doubleword aligned");
		end
	endgenerate

	// ----------------------------------------------------------------
	// Index field extraction
	// ----------------------------------------------------------------
	function automatic logic [7:0] f_bus(input logic [31:0] idx);
		f_bus = idx[`IOCA_BUS_HI:`IOCA_BUS_LO];
	endfunction

	function automatic logic [4:0] f_dev(input logic [31:0] idx);
		f_dev = idx[`IOCA_DEV_HI:`IOCA_DEV_LO];
	endfunction

	function automatic logic [2:0] f_fun(input logic [31:0] idx);
		f_fun = idx[`IOCA_FUN_HI:`IOCA_FUN_LO];
	endfunction

	function automatic logic [5:0] f_reg(input logic [31:0] idx);
		f_reg = idx[`IOCA_REG_HI:`IOCA_REG_LO];
	endfunction

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	function automatic logic is_dword(input logic [3:0] be);
		is_dword = (be == `IOCA_BE_DWORD);
	endfunction

	function automatic ioca_target_type route(input logic [31:0] idx,
		input logic [7:0] sec, input logic [7:0] sub, input logic int_dev);
		logic [7:0] bus;
		logic [4:0] dev;
		logic [2:0] fun;
		bus = f_bus(idx);
		dev = f_dev(idx);
		fun = f_fun(idx);
		if (bus == 8'h00)
		begin
			if (int_dev)
				route = (fun < N_INT_FUN) ? IOCA_TGT_INT
					: IOCA_TGT_NONE;
			else
				route = IOCA_TGT_HUB_T0;
		end
		else if (bus == sec)
			route = (dev == 5'h00) ? IOCA_TGT_PCIE_T0 : IOCA_TGT_ABORT;
		else if (bus > sec && bus <= sub)
			route = IOCA_TGT_PCIE_T1;
		else
			route = IOCA_TGT_HUB_T1;
	endfunction

	// ----------------------------------------------------------------
	// Input capture
	// ----------------------------------------------------------------
	// The requester runs on clk_sys, so its cycle is registered once to
	// keep every output a plain flip-flop and the decode off the output path.
	logic [31:0] index_reg;
	logic        hit_index;
	logic        hit_data;
	logic        index_dw;

	assign hit_index = io_req.valid && io_req.addr == `IOCA_INDEX_ADDR;
	assign hit_data  = io_req.valid && io_req.addr == `IOCA_DATA_ADDR;
	assign index_dw  = hit_index && is_dword(io_req.byte_en);

	// ----------------------------------------------------------------
	// Internal device match on bus zero
	// ----------------------------------------------------------------
	// One comparator per internal device number; widening N_INT_DEV
	// adds devices without touching the route function.
	logic [N_INT_DEV-1:0] int_dev_hit;
	logic                 int_dev_any;

	genvar gi;
	generate
		for (gi = 0; gi < N_INT_DEV; gi++)
		begin : g_int_dev
			assign int_dev_hit[gi] = (f_dev(index_reg) == 5'(gi));
		end
	endgenerate

	assign int_dev_any = |int_dev_hit;

	// ----------------------------------------------------------------
	// Index register
	// ----------------------------------------------------------------
	// Only a full doubleword write moves the index; a narrower write to
	// the same address belongs to the hub link and must leave it alone.
	logic [31:0] next_index;

	always_comb
	begin
		next_index = index_reg;
		if (index_dw && io_req.write)
			next_index = io_req.wdata & `IOCA_INDEX_MASK;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			index_reg <= `IOCA_INDEX_RESET;
		else
			index_reg <= next_index;
	end

	// ----------------------------------------------------------------
	// Read answer for the index register
	// ----------------------------------------------------------------
	logic        next_rd_valid;
	logic [31:0] next_rdata;

	always_comb
	begin
		next_rd_valid = index_dw && !io_req.write;
		next_rdata    = next_rd_valid ? index_reg : 32'h0000_0000;
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			io_rd_valid <= 1'b0;
		else
			io_rd_valid <= next_rd_valid;
	end

	// Zero outside a read answer, so a stale index never lingers on the bus
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			io_rdata <= 32'h0000_0000;
		else
			io_rdata <= next_rdata;
	end

	// ----------------------------------------------------------------
	// Configuration request through the data window
	// ----------------------------------------------------------------
	logic cfg_go;
	assign cfg_go = hit_data && index_reg[`IOCA_EN_BIT];

	// Target and fields are latched with the strobe, so the path that takes
	// the request sees one consistent index even if it is rewritten at once.
	ioca_target_type next_target;

	always_comb
	begin
		next_target = IOCA_TGT_NONE;
		if (cfg_go)
			next_target = route(index_reg, port_secondary_bus, port_subordinate_bus,
				int_dev_any);
	end

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cfg_en     <= 1'b0;
			cfg_target <= IOCA_TGT_NONE;
			cfg_req    <= '0;
		end
		else
		begin
			cfg_en             <= index_reg[`IOCA_EN_BIT];
			cfg_target         <= next_target;
			cfg_req.valid      <= cfg_go;
			cfg_req.write      <= io_req.write;
			cfg_req.bus        <= index_reg[`IOCA_BUS_HI:`IOCA_BUS_LO];
			cfg_req.dev        <= index_reg[`IOCA_DEV_HI:`IOCA_DEV_LO];
			cfg_req.fun        <= index_reg[`IOCA_FUN_HI:`IOCA_FUN_LO];
			cfg_req.regnum     <= index_reg[`IOCA_REG_HI:`IOCA_REG_LO];
			cfg_req.byte_en    <= io_req.byte_en;
			cfg_req.wdata      <= io_req.wdata;
		end
	end

	// ----------------------------------------------------------------
	// Address and header field mapping
	// ----------------------------------------------------------------
	// Hub link address: the bus byte only matters for Type 1 cycles;
	// a Type 0 cycle carries bus zero there, which is the field itself.
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			hub_cfg_addr <= 32'h0000_0000;
		else if (cfg_go)
			hub_cfg_addr <= {8'h00,
				f_bus(index_reg),
				f_dev(index_reg),
				f_fun(index_reg),
				f_reg(index_reg), 2'b00};
	end

	// Express header bytes packed as [23:16] byte 8 bus,
	// [15:8] byte 6 device and function, [7:0] byte 7 register.
	// Holding them here lets the link side build the header with no
	// second look at the index, which may already have been rewritten.
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			pcie_hdr_dw2 <= 32'h0000_0000;
		else if (cfg_go)
			pcie_hdr_dw2 <= {8'h00,
				f_bus(index_reg),
				f_dev(index_reg),
				f_fun(index_reg),
				f_reg(index_reg), 2'b00};
	end

	// ----------------------------------------------------------------
	// Ordinary I/O pass-through to the hub link
	// ----------------------------------------------------------------
	// Partial index accesses and data accesses while disabled go down as
	// plain I/O; other addresses are outside this block's decode.
	logic fwd_go;
	assign fwd_go = (hit_index && !is_dword(io_req.byte_en))
		|| (hit_data && !index_reg[`IOCA_EN_BIT]);

	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			io_fwd <= '0;
		else
		begin
			io_fwd.valid   <= fwd_go;
			io_fwd.write   <= io_req.write;
			io_fwd.addr    <= io_req.addr;
			io_fwd.byte_en <= io_req.byte_en;
			io_fwd.wdata   <= io_req.wdata;
		end
	end

endmodule

// [ioca_defines.svh]
`ifndef IOCA_DEFINES_SVH
`define IOCA_DEFINES_SVH

// I/O addresses of the index and data window registers
`define IOCA_INDEX_ADDR      16'h0CF8
`define IOCA_DATA_ADDR       16'h0CFC
`define IOCA_INDEX_RESET     32'h0000_0000
// Index register field positions
`define IOCA_EN_BIT          31
`define IOCA_BUS_HI          23
`define IOCA_BUS_LO          16
`define IOCA_DEV_HI          15
`define IOCA_DEV_LO          11
`define IOCA_FUN_HI          10
`define IOCA_FUN_LO          8
`define IOCA_REG_HI          7
`define IOCA_REG_LO          2
// Writable bits of the index register; reserved bits stay zero
`define IOCA_INDEX_MASK      32'h80FF_FFFC
// Internal devices on bus zero and functions they answer
`define IOCA_DEV_HOST        5'h00
`define IOCA_DEV_PORT        5'h01
`define IOCA_DEV_LAST_INT    5'h02
`define IOCA_FUN_LAST_INT    3'h1
// Full doubleword byte enables
`define IOCA_BE_DWORD        4'hF

`endif

// [ioca_pkg.sv]
package ioca_pkg;

	// Processor I/O cycle as seen by the hub
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [3:0]  byte_en;
		logic [31:0] wdata;
	} ioca_io_req_type;

	// Where a cycle is sent
	typedef enum logic [6:0] {
		IOCA_TGT_NONE    = 7'b0000001,
		IOCA_TGT_INT     = 7'b0000010,
		IOCA_TGT_HUB_T0  = 7'b0000100,
		IOCA_TGT_HUB_T1  = 7'b0001000,
		IOCA_TGT_PCIE_T0 = 7'b0010000,
		IOCA_TGT_PCIE_T1 = 7'b0100000,
		IOCA_TGT_ABORT   = 7'b1000000
	} ioca_target_type;

	// Configuration request handed to the chosen path
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [7:0]  bus;
		logic [4:0]  dev;
		logic [2:0]  fun;
		logic [5:0]  regnum;
		logic [3:0]  byte_en;
		logic [31:0] wdata;
	} ioca_cfg_req_type;

	// Ordinary I/O cycle passed down the hub link
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [3:0]  byte_en;
		logic [31:0] wdata;
	} ioca_io_fwd_type;

endpackage

// [ioca_decoder_assertions.sv]
`timescale 1ns/1ns
module ioca_decoder_assertions
(
	input wire logic                      clk_sys,
	input wire logic                      rst_b,
	input wire ioca_pkg::ioca_io_req_type  io_req,
	input wire logic                      io_rd_valid,
	input wire logic [31:0]               io_rdata,
	input wire logic                      cfg_en,
	input wire ioca_pkg::ioca_target_type  cfg_target,
	input wire ioca_pkg::ioca_cfg_req_type cfg_req,
	input wire logic [31:0]               hub_cfg_addr,
	input wire logic [31:0]               pcie_hdr_dw2,
	input wire ioca_pkg::ioca_io_fwd_type  io_fwd
);
	import ioca_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	logic idx_acc;
	logic dat_acc;
	logic dword;
	assign idx_acc = io_req.valid && io_req.addr == 16'h0CF8;
	assign dat_acc = io_req.valid && io_req.addr == 16'h0CFC;
	assign dword = io_req.byte_en == 4'hF;
	a_index_read: assert property (idx_acc && !io_req.write && dword |=> io_rd_valid
		&& io_rdata[30:24] == 7'h00 && io_rdata[1:0] == 2'b00) else $error("index read");
	a_dword_claim: assert property (idx_acc && dword |=> !io_fwd.valid) else $error("claim");
	a_partial_pass: assert property (idx_acc && !dword |=> io_fwd.valid && !io_rd_valid)
		else $error("partial access not passed on");
	a_enable_track: assert property (idx_acc && io_req.write && dword
		|=> ##1 cfg_en == $past(io_req.wdata[31], 2)) else $error("enable bit");
	// Previous cycle quiet, so cfg_en already reflects the stored index
	a_data_cfg: assert property (dat_acc && cfg_en && !$past(io_req.valid) |=> !io_fwd.valid)
		else $error("enabled data access forwarded");
	a_data_plain: assert property (dat_acc && !cfg_en && !$past(io_req.valid)
		|=> io_fwd.valid && !cfg_req.valid) else $error("disabled data access");
	a_hub_fields: assert property (cfg_req.valid |-> hub_cfg_addr == {8'h00, cfg_req.bus,
		cfg_req.dev, cfg_req.fun, cfg_req.regnum, 2'b00}) else $error("hub address");
	a_hdr_fields: assert property (cfg_req.valid |-> pcie_hdr_dw2 == {8'h00, cfg_req.bus,
		cfg_req.dev, cfg_req.fun, cfg_req.regnum, 2'b00}) else $error("header bytes");
	a_bus0_ext: assert property (cfg_req.valid && cfg_req.bus == 8'h00 && cfg_req.dev > 5'h02
		|-> cfg_target == IOCA_TGT_HUB_T0) else $error("bus zero external");
endmodule
bind ioca_decoder ioca_decoder_assertions u_ioca_decoder_assertions (.*);

// [ioca_host.sv]
`timescale 1ns/1ns
module ioca_host
(
	input  wire logic                 clk_sys,
	output ioca_pkg::ioca_io_req_type io_req
);
	import ioca_pkg::*;
	initial io_req = '0;
	// One request per call; valid drops for a cycle so calls never merge
	task automatic cyc(input logic w, input logic [15:0] a, input logic [3:0] be,
		input logic [31:0] d);
		@(posedge clk_sys);
		io_req <= '{1'b1, w, a, be, d};
		@(posedge clk_sys);
		io_req.valid <= 1'b0;
		#1;
	endtask
endmodule

// [ioca_decoder_tb_top.sv]
`timescale 1ns/1ns
module ioca_decoder_tb_top;
	import ioca_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] sec_bus = 8'h05;
	logic [7:0] sub_bus = 8'h09;
	ioca_io_req_type io_req;
	logic io_rd_valid, cfg_en;
	logic [31:0] io_rdata, hub_cfg_addr, pcie_hdr_dw2;
	ioca_target_type cfg_target;
	ioca_cfg_req_type cfg_req;
	ioca_io_fwd_type io_fwd;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	logic [31:0] idx [7] = '{32'h8000_0004, 32'h8000_0208, 32'h8000_1A24, 32'h8020_0010,
		32'h8005_00FC, 32'h8005_0800, 32'h8009_0040};
	ioca_target_type tgt [7] = '{IOCA_TGT_INT, IOCA_TGT_NONE, IOCA_TGT_HUB_T0,
		IOCA_TGT_HUB_T1, IOCA_TGT_PCIE_T0, IOCA_TGT_ABORT, IOCA_TGT_PCIE_T1};
	ioca_host u_ioca_host (.clk_sys(clk_sys), .io_req(io_req));
	ioca_decoder u_ioca_decoder (.clk_sys(clk_sys), .rst_b(rst_b), .io_req(io_req),
		.port_secondary_bus(sec_bus), .port_subordinate_bus(sub_bus),
		.io_rd_valid(io_rd_valid), .io_rdata(io_rdata), .cfg_en(cfg_en),
		.cfg_target(cfg_target), .cfg_req(cfg_req), .hub_cfg_addr(hub_cfg_addr),
		.pcie_hdr_dw2(pcie_hdr_dw2), .io_fwd(io_fwd));
	initial forever #50 clk_sys = ~clk_sys;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Whole run needs well under 200 cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fails++;
			complete_run();
		end
	end
	initial
	begin
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		u_ioca_host.cyc(1'b0, 16'h0CF8, 4'hF, 32'h0);
		chk(io_rdata, 32'h0);
		chk(io_rd_valid, 1'b1);
		chk(cfg_en, 1'b0);
		$display("test reset done");
		u_ioca_host.cyc(1'b1, 16'h0CF8, 4'hF, 32'hFFFF_FFFF);
		u_ioca_host.cyc(1'b1, 16'h0CF8, 4'h1, 32'h0);
		chk(io_fwd.valid, 1'b1);
		chk({io_fwd.write, io_fwd.addr, io_fwd.byte_en}, {1'b1, 16'h0CF8, 4'h1});
		u_ioca_host.cyc(1'b0, 16'h0CF8, 4'hF, 32'h0);
		chk(io_rdata, 32'h80FF_FFFC);
		chk(cfg_en, 1'b1);
		$display("test index register done");
		for (int i = 0; i < 7; i++)
		begin
			u_ioca_host.cyc(1'b1, 16'h0CF8, 4'hF, idx[i]);
			u_ioca_host.cyc(1'b0, 16'h0CFC, 4'hF, 32'h0);
			chk(cfg_target, tgt[i]);
			chk({cfg_req.valid, cfg_req.write, cfg_req.byte_en, cfg_req.bus, cfg_req.dev,
				cfg_req.fun, cfg_req.regnum}, {2'b10, 4'hF, idx[i][23:2]});
			if (tgt[i] != IOCA_TGT_NONE)
			begin
				chk(hub_cfg_addr, idx[i] & 32'h00FF_FFFC);
				chk(pcie_hdr_dw2, idx[i] & 32'h00FF_FFFC);
			end
		end
		$display("test routing done");
		u_ioca_host.cyc(1'b1, 16'h0CF8, 4'hF, 32'h0000_1800);
		u_ioca_host.cyc(1'b1, 16'h0CFC, 4'hF, 32'h1234_5678);
		chk({io_fwd.valid, cfg_req.valid}, 2'b10);
		chk(io_fwd.wdata, 32'h1234_5678);
		u_ioca_host.cyc(1'b0, 16'h0080, 4'hF, 32'h0);
		chk({io_fwd.valid, io_rd_valid}, 2'b00);
		$display("test pass through done");
		complete_run();
	end
endmodule
